// >>> shared/gbsms_pkg.sv
// Package with field layout, timing and enumerations for the gain bank and servo mode block.
package gbsms_pkg;
  localparam int          GBSMS_WORD_W       = 32;
  localparam int          GBSMS_GSEL_LSB     = 8;
  localparam int          GBSMS_GSEL_W       = 4;
  localparam int          GBSMS_BANK_W       = 2;
  localparam int          GBSMS_SVMOD_BIT    = 30;
  localparam int          GBSMS_VPPI_BIT     = 4;
  localparam int          GBSMS_PCL_BIT      = 6;
  localparam int          GBSMS_NCL_BIT      = 7;
  localparam int          GBSMS_NBANKS       = 4;
  localparam int          GBSMS_GAIN_W       = 16;
  localparam logic [31:0] GBSMS_USED_MASK    = 32'h4000_0fd0;
  localparam logic [3:0]  GBSMS_AUTO_MANUAL  = 4'h0;
  localparam logic [3:0]  GBSMS_AUTO_ON      = 4'h1;
  localparam int          GBSMS_SETTLE_US    = 2000;
  localparam int          GBSMS_CLK_MHZ      = 200;
  localparam int          GBSMS_SETTLE_CYC   = GBSMS_SETTLE_US * GBSMS_CLK_MHZ;
  localparam logic [1:0]  GBSMS_CMD_OTHER    = 2'h0;
  localparam logic [1:0]  GBSMS_CMD_INTERP   = 2'h1;
  localparam logic [1:0]  GBSMS_CMD_INDEX    = 2'h2;
  localparam logic [1:0]  GBSMS_CMD_QUICK    = 2'h3;
  typedef enum logic [1:0] {
    GBSMS_SV_OFF    = 2'b00,
    GBSMS_SV_MANUAL = 2'b01,
    GBSMS_SV_AUTO   = 2'b11
  } gbsms_sv_e;
endpackage

// >>> shared/gbsms_bank_if.sv
// Interface carrying the bank select and the selected gain set.
interface gbsms_bank_if #(parameter int GW = 16);
  logic [1:0]    bank;
  logic [GW-1:0] speed_gain;
  logic [GW-1:0] speed_integral;
  logic [GW-1:0] position_gain;
  logic [GW-1:0] torque_filter;
  modport ctrl (output bank, input speed_gain, speed_integral, position_gain, torque_filter);
  modport bank_side (input bank, output speed_gain, speed_integral, position_gain, torque_filter);
endinterface

// >>> rtl/gbsms_bank_sel.sv
// Gain bank store: per-bank gain set registers and the selection mux.
module gbsms_bank_sel
  import gbsms_pkg::*;
#(
  parameter int GW = GBSMS_GAIN_W,
  parameter int NB = GBSMS_NBANKS
)(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             gain_wr,
  input  wire logic [1:0]       gain_wr_bank,
  input  wire logic [4*GW-1:0]  gain_wr_data,
  gbsms_bank_if.bank_side       bif
);
  logic [4*GW-1:0] set_q [NB];

  // Each bank keeps its own set; a write touches only the addressed bank.
  for (genvar b = 0; b < NB; b++)
  begin : g_bank
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
        set_q[b] <= '0;
      else if (gain_wr && gain_wr_bank == 2'(b))
        set_q[b] <= gain_wr_data;
    end
  end

  wire logic [4*GW-1:0] sel_set = set_q[bif.bank];
  assign bif.speed_gain     = sel_set[GW-1:0];
  assign bif.speed_integral = sel_set[2*GW-1:GW];
  assign bif.position_gain  = sel_set[3*GW-1:2*GW];
  assign bif.torque_filter  = sel_set[4*GW-1:3*GW];
endmodule

// >>> rtl/gbsms_top.sv
// Servo command word interpreter: gain bank selection and servo mode control.
//
// Contract
// - Active gain bank comes from the four-bit field at bit 8 of the command word.
// - Each bank holds its own gain set; the selected bank's set is used.
// - Bit 30 of the command word disables (0) or enables (1) servo mode.
// - Auto switching digit defaults to 0, 1 selects auto, applies at restart.
// - Auto switching enables servo mode on interpolate, index and quick commands.
// - Auto mode keeps servo mode on if bit 30 clears and raises a warning; the code does so only while an auto-switching command is in flight.
module gbsms_top
  import gbsms_pkg::*;
#(
  parameter int GW         = GBSMS_GAIN_W,
  parameter int SETTLE_CYC = GBSMS_SETTLE_CYC
)(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             servo_command_io_word_wr,
  input  wire logic [31:0]      servo_command_io_word,
  input  wire logic             motion_cmd_valid,
  input  wire logic [1:0]       motion_cmd_kind,
  input  wire logic             motion_cmd_done,
  input  wire logic [3:0]       auto_servo_mode_param,
  input  wire logic             gain_wr,
  input  wire logic [1:0]       gain_wr_bank,
  input  wire logic [4*GW-1:0]  gain_wr_data,
  output logic [1:0]            active_bank,
  output logic [GW-1:0]         speed_gain,
  output logic [GW-1:0]         speed_integral,
  output logic [GW-1:0]         position_gain,
  output logic [GW-1:0]         torque_filter,
  output logic                  servo_mode_enable,
  output logic                  auto_mode_active,
  output logic                  servo_mode_disable_warning,
  output logic                  gain_settled,
  output logic                  speed_loop_mode_bit,
  output logic                  forward_torque_limit_bit,
  output logic                  reverse_torque_limit_bit
);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  gbsms_bank_if #(.GW(GW)) bif ();

  logic [3:0]      gsel_q;
  logic            svmod_q;
  logic            auto_q;
  logic            strap_done;
  logic            auto_cmd_run;
  logic [CW-1:0]   settle_cnt;
  gbsms_sv_e       sv_state;
  gbsms_sv_e       next_sv_state;

  // Only documented fields are looked at; reserved bits are masked off.
  wire logic [31:0] cmd_used  = servo_command_io_word & GBSMS_USED_MASK;
  wire logic [3:0]  gsel_new  = cmd_used[GBSMS_GSEL_LSB +: GBSMS_GSEL_W];
  wire logic        svmod_new = cmd_used[GBSMS_SVMOD_BIT];
  wire logic        vppi_new  = cmd_used[GBSMS_VPPI_BIT];
  wire logic        pcl_new   = cmd_used[GBSMS_PCL_BIT];
  wire logic        ncl_new   = cmd_used[GBSMS_NCL_BIT];
  // Kind zero covers every other motion command, which leaves servo mode alone.
  wire logic        auto_kind = motion_cmd_kind == GBSMS_CMD_INTERP ||
                                motion_cmd_kind == GBSMS_CMD_INDEX  ||
                                motion_cmd_kind == GBSMS_CMD_QUICK;
  wire logic        auto_start = auto_q && motion_cmd_valid && auto_kind;
  wire logic        auto_hold  = auto_start || auto_cmd_run;
  // Rewriting the same four-bit select field does not restart the timer, so a host may repeat its word.
  wire logic        gsel_change = servo_command_io_word_wr && gsel_new != gsel_q;
  // A disable is judged against the command in flight, including one starting now.
  wire logic        disable_try = servo_command_io_word_wr && !svmod_new && auto_hold;

  // Gain select and servo mode bit are latched on each command word write.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gsel_q  <= '0;
      svmod_q <= 1'b0;
    end
    else if (servo_command_io_word_wr)
    begin
      gsel_q  <= gsel_new;
      svmod_q <= svmod_new;
    end
  end

  // Loop mode and torque limit bits are registered copies of the last word.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      speed_loop_mode_bit      <= 1'b0;
      forward_torque_limit_bit <= 1'b0;
      reverse_torque_limit_bit <= 1'b0;
    end
    else if (servo_command_io_word_wr)
    begin
      speed_loop_mode_bit      <= vppi_new;
      forward_torque_limit_bit <= pcl_new;
      reverse_torque_limit_bit <= ncl_new;
    end
  end

  // Banks are 0 to 3, so only the low bits of the field select one.
  assign bif.bank    = gsel_q[GBSMS_BANK_W-1:0];
  assign active_bank = gsel_q[GBSMS_BANK_W-1:0];

  // The store only answers for the bank named here; writes to other banks stay hidden.
  gbsms_bank_sel #(.GW(GW), .NB(GBSMS_NBANKS)) u_bank (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .gain_wr      (gain_wr),
    .gain_wr_bank (gain_wr_bank),
    .gain_wr_data (gain_wr_data),
    .bif          (bif)
  );

  // Outputs are registered so a bank switch reaches the loops in one clean step.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      speed_gain     <= '0;
      speed_integral <= '0;
      position_gain  <= '0;
      torque_filter  <= '0;
    end
    else
    begin
      speed_gain     <= bif.speed_gain;
      speed_integral <= bif.speed_integral;
      position_gain  <= bif.position_gain;
      torque_filter  <= bif.torque_filter;
    end
  end

  // The parameter is a setup value: it is captured once after reset release, so a
  // later change needs a restart to take effect.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_done <= 1'b0;
      auto_q     <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      auto_q     <= auto_servo_mode_param == GBSMS_AUTO_ON;
    end
  end
  assign auto_mode_active = auto_q;

  // Tracks an auto-switching command from its start until it finishes.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      auto_cmd_run <= 1'b0;
    else if (auto_start)
      auto_cmd_run <= 1'b1;
    else if (motion_cmd_done)
      auto_cmd_run <= 1'b0;
  end

  // Gray-coded servo mode state: off, manual on, held on by auto switching.
  always_comb
  begin
    next_sv_state = sv_state;
    unique case (sv_state)
      GBSMS_SV_OFF:
        if (auto_start)
          next_sv_state = GBSMS_SV_AUTO;
        else if (svmod_q)
          next_sv_state = GBSMS_SV_MANUAL;
      GBSMS_SV_MANUAL:
        if (auto_start)
          next_sv_state = GBSMS_SV_AUTO;
        else if (!svmod_q)
          next_sv_state = GBSMS_SV_OFF;
      GBSMS_SV_AUTO:
        if (!auto_hold)
          next_sv_state = svmod_q ? GBSMS_SV_MANUAL : GBSMS_SV_OFF;
      // The unused code falls back to off, so an upset cannot latch servo mode on.
      default:
        next_sv_state = GBSMS_SV_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sv_state <= GBSMS_SV_OFF;
    else
      sv_state <= next_sv_state;
  end

  // The host relies on this flag for position control; it never drops while auto holds.
  assign servo_mode_enable = sv_state != GBSMS_SV_OFF;

  // Warning is a one-cycle pulse per refused disable attempt.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      servo_mode_disable_warning <= 1'b0;
    else
      servo_mode_disable_warning <= disable_try;
  end

  // Settling timer after a bank change; the host must wait for it before motion.
  // The timer is status only: an early command is still obeyed, so the host must honour it.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      settle_cnt <= '0;
    else if (gsel_change)
      settle_cnt <= CW'(SETTLE_CYC);
    else if (settle_cnt != '0)
      settle_cnt <= settle_cnt - CW'(1);
  end
  assign gain_settled = settle_cnt == '0;
endmodule

// >>> test/gbsms_checker.sv
// Port-level assertions for the gain bank and servo mode block.
module gbsms_checker
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        servo_command_io_word_wr,
  input  wire logic [31:0] servo_command_io_word,
  input  wire logic        motion_cmd_valid,
  input  wire logic [1:0]  motion_cmd_kind,
  input  wire logic [1:0]  active_bank,
  input  wire logic        servo_mode_enable,
  input  wire logic        auto_mode_active,
  input  wire logic        servo_mode_disable_warning,
  input  wire logic        gain_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  chk_bank_field: assert property (
    servo_command_io_word_wr |=> active_bank == $past(servo_command_io_word[9:8]))
    else $error("active bank differs from gain select field");
  chk_mode_bit: assert property (
    !auto_mode_active && servo_command_io_word_wr
      |-> ##2 servo_mode_enable == $past(servo_command_io_word[30], 2))
    else $error("servo mode does not follow bit 30");
  chk_param_held: assert property (
    $past(rstn, 2) |-> $stable(auto_mode_active))
    else $error("auto switching changed without restart");
  chk_auto_start: assert property (
    auto_mode_active && motion_cmd_valid && motion_cmd_kind != 2'h0 |=> servo_mode_enable)
    else $error("auto command did not enable servo mode");
  chk_warn_cause: assert property (
    servo_mode_disable_warning |-> auto_mode_active && $past(servo_command_io_word_wr)
      && !$past(servo_command_io_word[30]))
    else $error("warning without a disable attempt");
  chk_warn_keeps: assert property (
    servo_mode_disable_warning |-> servo_mode_enable)
    else $error("servo mode dropped on refused disable");
  chk_settle_drop: assert property (
    active_bank != $past(active_bank) |-> !gain_settled)
    else $error("gain settled flag high right after a bank change");
endmodule
bind gbsms_top gbsms_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .servo_command_io_word_wr(servo_command_io_word_wr),
  .servo_command_io_word(servo_command_io_word), .motion_cmd_valid(motion_cmd_valid),
  .motion_cmd_kind(motion_cmd_kind), .active_bank(active_bank),
  .servo_mode_enable(servo_mode_enable), .auto_mode_active(auto_mode_active),
  .servo_mode_disable_warning(servo_mode_disable_warning), .gain_settled(gain_settled));

// >>> test/gbsms_host.sv
// Behavioural host controller driving command words and motion commands.
module gbsms_host
  import gbsms_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        gain_settled,
  output logic             wr,
  output logic [31:0]      word,
  output logic             valid,
  output logic [1:0]       kind,
  output logic             done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr = 1'b0;
    word = 32'h0;
    valid = 1'b0;
    kind = 2'h0;
    done = 1'b0;
  end
  // A released bus shows the inverse so a stale word can never look valid.
  task automatic send(input logic [31:0] w);
    @(posedge ref_clk);
    wr <= 1'b1;
    word <= w & GBSMS_USED_MASK;
    @(posedge ref_clk);
    wr <= 1'b0;
    word <= ~(w & GBSMS_USED_MASK);
  endtask
  task automatic motion(input logic [1:0] k);
    @(posedge ref_clk);
    valid <= 1'b1;
    kind <= k;
    @(posedge ref_clk);
    valid <= 1'b0;
    kind <= ~k;
  endtask
  task automatic stop();
    @(posedge ref_clk);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
  endtask
  // Waits out the settling time before any motion command may follow.
  task automatic settle(output logic ok);
    @(negedge ref_clk);
    for (int i = 0; i < 100 && gain_settled !== 1'b1; i++)
      @(negedge ref_clk);
    ok = gain_settled;
    @(posedge ref_clk);
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the gain bank and servo mode block.
module tb_top
  import gbsms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rstn, wr, valid, done, gain_wr, chk, ok, a, sv, am, vp, fl, rl;
  logic [31:0] word, w;
  logic [1:0]  kind, gain_wr_bank, active_bank;
  logic [3:0]  param;
  logic [63:0] gain_wr_data;
  logic [63:0] gset [4];
  logic [15:0] sg, si, pg, tf;
  logic [71:0] q [$];
  logic [71:0] exp_v, obs;
  int          errors = 0;
  int          comparisons = 0;
  assign obs = {am, vp, fl, rl, active_bank, sv, a, tf, pg, si, sg};
  always #2.5 ref_clk = ~ref_clk;
  gbsms_top #(.SETTLE_CYC(20)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .servo_command_io_word_wr(wr), .servo_command_io_word(word), .motion_cmd_valid(valid),
    .motion_cmd_kind(kind), .motion_cmd_done(done), .auto_servo_mode_param(param),
    .gain_wr(gain_wr), .gain_wr_bank(gain_wr_bank), .gain_wr_data(gain_wr_data),
    .active_bank(active_bank), .speed_gain(sg), .speed_integral(si), .position_gain(pg),
    .torque_filter(tf), .servo_mode_enable(sv), .auto_mode_active(am),
    .servo_mode_disable_warning(a), .gain_settled(ok), .speed_loop_mode_bit(vp),
    .forward_torque_limit_bit(fl), .reverse_torque_limit_bit(rl));
  gbsms_host host (.ref_clk(ref_clk), .gain_settled(ok), .wr(wr), .word(word),
    .valid(valid), .kind(kind), .done(done));
  always @(negedge ref_clk)
    if (chk)
    begin
      exp_v = q.pop_front();
      comparisons++;
      if (obs !== exp_v)
      begin
        errors++;
        $display("MISMATCH outputs expected %h seen %h", exp_v, obs);
      end
    end
  task automatic note(input logic [71:0] v);
    q.push_back(v);
    chk <= 1'b1;
    @(posedge ref_clk);
    chk <= 1'b0;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_settled();
    logic s;
    host.settle(s);
    if (s !== 1'b1)
    begin
      errors++;
      $display("MISMATCH gain_settled expected 1 seen %b", s);
      test_done();
    end
  endtask
  task automatic run(input logic [3:0] p);
    logic        e;
    logic        m;
    logic [2:0]  lim;
    logic [31:0] v;
    @(posedge ref_clk);
    rstn <= 1'b0;
    param <= p;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    m = (p == GBSMS_AUTO_ON);
    // The setup digit counts only at restart, so this late change must not show.
    param <= m ? GBSMS_AUTO_MANUAL : GBSMS_AUTO_ON;
    for (int i = 0; i < 4; i++)
    begin
      gset[i] = {$urandom, $urandom};
      gain_wr <= 1'b1;
      gain_wr_bank <= 2'(i);
      gain_wr_data <= gset[i];
      @(posedge ref_clk);
    end
    gain_wr <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      w = $urandom;
      w[GBSMS_SVMOD_BIT] = i[0];
      w[9:8] = 2'(i);
      lim = {w[GBSMS_VPPI_BIT], w[GBSMS_PCL_BIT], w[GBSMS_NCL_BIT]};
      host.send(w);
      wait_settled();
      note({m, lim, 2'(i), i[0], 1'b0, gset[i]});
    end
    // Without auto switching the host turns servo mode on itself for position moves.
    v = 32'h0000_0300;
    v[GBSMS_SVMOD_BIT] = !m;
    for (int k = 0; k < 4; k++)
    begin
      host.send(v);
      wait_settled();
      host.motion(2'(k));
      @(posedge ref_clk);
      e = m && (k != 0);
      note({m, 3'b000, 2'h3, e | v[GBSMS_SVMOD_BIT], 1'b0, gset[3]});
      host.send(v);
      note({m, 3'b000, 2'h3, e | v[GBSMS_SVMOD_BIT], e, gset[3]});
      host.stop();
      repeat (2) @(posedge ref_clk);
      note({m, 3'b000, 2'h3, v[GBSMS_SVMOD_BIT], 1'b0, gset[3]});
    end
  endtask
  initial
  begin
    void'($urandom(32'h032c8702));
    rstn = 1'b0;
    param = 4'h0;
    gain_wr = 1'b0;
    gain_wr_bank = 2'h0;
    gain_wr_data = 64'h0;
    chk = 1'b0;
    run(GBSMS_AUTO_MANUAL);
    run(GBSMS_AUTO_ON);
    test_done();
  end
endmodule
